/* power_mode_pkg.sv */
// Shared constants and types for the power-mode and module-clock controller
package power_mode_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_SYSTEM_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFS_SYSTEM_CONTROL_TWO = 8'h04;
    localparam logic [7:0] OFS_CLOCK_HALT_ONE     = 8'h08;
    localparam logic [7:0] OFS_MODE_STATUS        = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS         = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLEAR          = 8'h14;
    localparam logic [7:0] OFS_IRQ_ENABLE         = 8'h18;

    // system_control_one fields
    localparam int SC1_LOW_SPEED_ON_BIT = 0;
    localparam int SC1_WATCH_SEL_BIT    = 1;
    localparam int SC1_SW_STANDBY_BIT   = 2;
    localparam logic [2:0] SC1_RESET    = 3'h0;

    // system_control_two fields
    localparam int SC2_SUB_FREQ_LO_BIT  = 0;
    localparam int SC2_SUB_FREQ_HI_BIT  = 1;
    localparam int SC2_MED_SPEED_BIT    = 2;
    localparam int SC2_DIRECT_BIT       = 3;
    localparam logic [3:0] SC2_RESET    = 4'h0;

    // clock_halt_one: one bit per peripheral, 1 = clocked
    localparam int NUM_MODULES          = 8;
    localparam int CH1_CONVERTER_BIT    = 0;
    localparam int CH1_TWO_WIRE_BIT     = 1;
    localparam logic [7:0] CH1_RESET    = 8'hFE;

    // mode_status fields
    localparam int MS_MODE_LSB          = 0;
    localparam int MS_FREQ_LSB          = 4;
    localparam int MS_LOCKED_BIT        = 8;

    // Interrupt status bits
    localparam int NUM_EVENTS           = 3;
    localparam int EV_DIRECT_DONE       = 0;
    localparam int EV_LOW_POWER_ENTRY   = 1;
    localparam int EV_WAKEUP            = 2;

    // Timing: watch clock derived from the system clock
    localparam int SYS_CLK_HZ           = 50_000_000;
    localparam int WATCH_CLK_HZ         = 32_768;
    localparam int WATCH_TICK_CYCLES    = SYS_CLK_HZ / WATCH_CLK_HZ;
    localparam int WATCH_DIV_W          = 11;
    localparam logic [WATCH_DIV_W-1:0] WATCH_DIV_LAST = WATCH_DIV_W'(WATCH_TICK_CYCLES - 1);
    localparam int SUB_DIV_W            = 3;

    localparam logic [1:0] AXI_OKAY     = 2'h0;
    localparam logic [1:0] AXI_SLVERR   = 2'h2;

    typedef enum logic [2:0] {
        MODE_ACTIVE,
        MODE_SLEEP,
        MODE_SUBACTIVE,
        MODE_SUBSLEEP,
        MODE_WATCH,
        MODE_WATCH_PASS
    } mode_t;

endpackage : power_mode_pkg

/* tick_divider.sv */
// Enable-pulse divider: one tick every (last_i + 1) input enables
`timescale 1ns/1ps
module tick_divider #(
    parameter int W = 3
) (
    input  wire logic         sys_clk_i,  // System clock
    input  wire logic         rst_i,      // Synchronous reset, active high
    input  wire logic         en_i,       // Input rate enable
    input  wire logic [W-1:0] last_i,     // Terminal count
    output logic              tick_o      // One-cycle output enable
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    assign tick_o = en_i && (cnt_reg >= last_i);

    always_comb begin
        cnt_next = cnt_reg;
        if (tick_o) begin
            cnt_next = '0;
        end else if (en_i) begin
            cnt_next = cnt_reg + W'(1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : tick_divider

/* power_mode_transition_ctrl.sv */
// Power-mode sequencer, subclock divider and module clock gating with AXI4-Lite registers
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module power_mode_transition_ctrl
    import power_mode_pkg::*;
(
    input  wire logic                   sys_clk_i,          // System clock, 50 MHz
    input  wire logic                   rst_i,              // Synchronous reset, active high
    // AXI4-Lite slave
    input  wire logic [7:0]             s_axi_awaddr,       // Write address
    input  wire logic                   s_axi_awvalid,      // Write address valid
    output logic                        s_axi_awready,      // Write address ready
    input  wire logic [31:0]            s_axi_wdata,        // Write data
    input  wire logic [3:0]             s_axi_wstrb,        // Write byte strobes
    input  wire logic                   s_axi_wvalid,       // Write data valid
    output logic                        s_axi_wready,       // Write data ready
    output logic [1:0]                  s_axi_bresp,        // Write response
    output logic                        s_axi_bvalid,       // Write response valid
    input  wire logic                   s_axi_bready,       // Write response ready
    input  wire logic [7:0]             s_axi_araddr,       // Read address
    input  wire logic                   s_axi_arvalid,      // Read address valid
    output logic                        s_axi_arready,      // Read address ready
    output logic [31:0]                 s_axi_rdata,        // Read data
    output logic [1:0]                  s_axi_rresp,        // Read response
    output logic                        s_axi_rvalid,       // Read data valid
    input  wire logic                   s_axi_rready,       // Read data ready
    // CPU side
    input  wire logic                   sleep_exec_i,       // Sleep instruction executed, pulse
    input  wire logic                   global_mask_i,      // CPU global interrupt mask bit
    input  wire logic                   irq_pending_i,      // Enabled interrupt request pending
    output logic [2:0]                  mode_o,             // Current power mode
    output logic                        cpu_run_o,          // CPU executes instructions
    output logic                        cpu_clk_en_o,       // CPU clock enable, held high in active, pulsed in subactive
    output logic                        cpu_medium_speed_o, // Active mode at medium speed
    output logic                        main_osc_en_o,      // Main oscillator enable
    output logic                        sub_clk_en_o,       // Subactive operating clock enable
    output logic [NUM_MODULES-1:0]      periph_clk_en_o,    // Per-peripheral clock enable
    output logic                        converter_standby_o,// Converter in module standby
    output logic                        direct_irq_o,       // Direct-transition exception, pulse
    output logic                        irq_o               // Level interrupt
);

    // ---------------- Register file ----------------
    logic [2:0]             sc1_reg, sc1_next;
    logic [3:0]             sc2_reg, sc2_next;
    logic [7:0]             ch1_reg, ch1_next;
    logic [NUM_EVENTS-1:0]  irq_stat_reg, irq_stat_next;
    logic [NUM_EVENTS-1:0]  irq_en_reg, irq_en_next;

    logic aw_held_reg, aw_held_next;
    logic w_held_reg, w_held_next;
    logic [7:0]  awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0]  wstrb_reg, wstrb_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        rvalid_reg, rvalid_next;
    logic [1:0]  rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;

    // ---------------- Mode state ----------------
    mode_t      mode_reg, mode_next;
    logic [1:0] freq_reg, freq_next;
    logic       locked_reg, locked_next;
    logic       direct_irq_reg, direct_irq_next;
    logic [NUM_EVENTS-1:0] event_set;

    logic watch_tick;
    logic sub_tick;
    logic wr_fire;
    logic [31:0] status_word;

    wire logic sw_standby  = sc1_reg[SC1_SW_STANDBY_BIT];
    wire logic watch_sel   = sc1_reg[SC1_WATCH_SEL_BIT];
    wire logic low_speed   = sc1_reg[SC1_LOW_SPEED_ON_BIT];
    wire logic med_speed   = sc2_reg[SC2_MED_SPEED_BIT];
    wire logic direct_on   = sc2_reg[SC2_DIRECT_BIT];
    wire logic sub_mode    = (mode_reg == MODE_SUBACTIVE) || (mode_reg == MODE_SUBSLEEP) ||
                             (mode_reg == MODE_WATCH) || (mode_reg == MODE_WATCH_PASS);

    // Watch clock stand-in derived from the system clock
    tick_divider #(.W(WATCH_DIV_W)) u_watch_div (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .en_i      (1'b1),
        .last_i    (WATCH_DIV_LAST),
        .tick_o    (watch_tick)
    );

    // Subactive clock: watch, /2, /4, /8 from the frequency applied at the last sleep
    tick_divider #(.W(SUB_DIV_W)) u_sub_div (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .en_i      (watch_tick),
        .last_i    (SUB_DIV_W'((4'h1 << freq_reg) - 4'h1)),
        .tick_o    (sub_tick)
    );

    // ---------------- AXI4-Lite write path ----------------
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;

    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next  = w_held_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            case (awaddr_reg)
                OFS_SYSTEM_CONTROL_ONE, OFS_SYSTEM_CONTROL_TWO, OFS_CLOCK_HALT_ONE,
                OFS_MODE_STATUS, OFS_IRQ_STATUS, OFS_IRQ_CLEAR,
                OFS_IRQ_ENABLE: bresp_next = AXI_OKAY;
                default:        bresp_next = AXI_SLVERR;
            endcase
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    // Register contents; only byte lane 0 carries any field
    always_comb begin
        sc1_next      = sc1_reg;
        sc2_next      = sc2_reg;
        ch1_next      = ch1_reg;
        irq_en_next   = irq_en_reg;
        irq_stat_next = irq_stat_reg;
        if (wr_fire && wstrb_reg[0]) begin
            case (awaddr_reg)
                OFS_SYSTEM_CONTROL_ONE: sc1_next    = wdata_reg[2:0];
                OFS_SYSTEM_CONTROL_TWO: sc2_next    = wdata_reg[3:0];
                OFS_CLOCK_HALT_ONE:     ch1_next    = wdata_reg[7:0];
                OFS_IRQ_CLEAR:  irq_stat_next = irq_stat_reg & ~wdata_reg[NUM_EVENTS-1:0];
                OFS_IRQ_ENABLE: irq_en_next   = wdata_reg[NUM_EVENTS-1:0];
                default: ;
            endcase
        end
        // A new event wins over a clear in the same cycle
        irq_stat_next = irq_stat_next | event_set;
    end

    // ---------------- AXI4-Lite read path ----------------
    assign s_axi_arready = !rvalid_reg;

    always_comb begin
        status_word = 32'h0;
        status_word[MS_MODE_LSB +: 3] = mode_reg;
        status_word[MS_FREQ_LSB +: 2] = freq_reg;
        status_word[MS_LOCKED_BIT]    = locked_reg;
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rresp_next  = rresp_reg;
        rdata_next  = rdata_reg;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = AXI_OKAY;
            rdata_next  = 32'h0;
            case (s_axi_araddr)
                OFS_SYSTEM_CONTROL_ONE: rdata_next[2:0] = sc1_reg;
                OFS_SYSTEM_CONTROL_TWO: rdata_next[3:0] = sc2_reg;
                OFS_CLOCK_HALT_ONE:     rdata_next[7:0] = ch1_reg;
                OFS_MODE_STATUS:        rdata_next      = status_word;
                OFS_IRQ_STATUS:         rdata_next[NUM_EVENTS-1:0] = irq_stat_reg;
                OFS_IRQ_CLEAR:          rdata_next      = 32'h0;
                OFS_IRQ_ENABLE:         rdata_next[NUM_EVENTS-1:0] = irq_en_reg;
                default:                rresp_next      = AXI_SLVERR;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // ---------------- Mode sequencer ----------------
    always_comb begin
        mode_next       = mode_reg;
        freq_next       = freq_reg;
        locked_next     = locked_reg;
        direct_irq_next = 1'b0;
        event_set       = '0;
        case (mode_reg)
            MODE_ACTIVE: begin
                if (sleep_exec_i) begin
                    freq_next = sc2_reg[SC2_SUB_FREQ_HI_BIT:SC2_SUB_FREQ_LO_BIT];
                    if (direct_on && global_mask_i) begin
                        // Masked direct request parks the CPU with no way out but reset
                        mode_next   = (sw_standby && watch_sel) ? MODE_WATCH : MODE_SLEEP;
                        locked_next = 1'b1;
                        event_set[EV_LOW_POWER_ENTRY] = 1'b1;
                    end else if (direct_on && sw_standby && watch_sel && low_speed) begin
                        mode_next = MODE_WATCH_PASS;
                    end else if (direct_on) begin
                        // Stay active at the newly chosen speed
                        direct_irq_next = 1'b1;
                        event_set[EV_DIRECT_DONE] = 1'b1;
                    end else begin
                        mode_next = (sw_standby && watch_sel) ? MODE_WATCH : MODE_SLEEP;
                        event_set[EV_LOW_POWER_ENTRY] = 1'b1;
                    end
                end
            end
            MODE_WATCH_PASS: begin
                // Waiting for the next watch tick, up to one watch period, lets the subclock settle
                if (watch_tick) begin
                    mode_next       = MODE_SUBACTIVE;
                    direct_irq_next = 1'b1;
                    event_set[EV_DIRECT_DONE] = 1'b1;
                end
            end
            MODE_SUBACTIVE: begin
                if (sleep_exec_i) begin
                    freq_next = sc2_reg[SC2_SUB_FREQ_HI_BIT:SC2_SUB_FREQ_LO_BIT];
                    if (direct_on && global_mask_i) begin
                        mode_next   = (sw_standby && watch_sel) ? MODE_WATCH : MODE_SUBSLEEP;
                        locked_next = 1'b1;
                        event_set[EV_LOW_POWER_ENTRY] = 1'b1;
                    end else if (direct_on) begin
                        // Low-speed bit picks staying subactive or going to active
                        mode_next       = low_speed ? MODE_SUBACTIVE : MODE_ACTIVE;
                        direct_irq_next = 1'b1;
                        event_set[EV_DIRECT_DONE] = 1'b1;
                    end else begin
                        mode_next = (sw_standby && watch_sel) ? MODE_WATCH : MODE_SUBSLEEP;
                        event_set[EV_LOW_POWER_ENTRY] = 1'b1;
                    end
                end
            end
            MODE_SLEEP, MODE_SUBSLEEP, MODE_WATCH: begin
                // Only an enabled, unmasked interrupt wakes; a locked mode never does
                if (irq_pending_i && !global_mask_i && !locked_reg) begin
                    event_set[EV_WAKEUP] = 1'b1;
                    if (mode_reg == MODE_SLEEP) begin
                        mode_next = MODE_ACTIVE;
                    end else if (mode_reg == MODE_SUBSLEEP) begin
                        mode_next = MODE_SUBACTIVE;
                    end else begin
                        mode_next = low_speed ? MODE_SUBACTIVE : MODE_ACTIVE;
                    end
                end
            end
            default: begin
                mode_next = MODE_ACTIVE;
            end
        endcase
    end

    // ---------------- Registers ----------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sc1_reg        <= SC1_RESET;
            sc2_reg        <= SC2_RESET;
            ch1_reg        <= CH1_RESET;
            irq_stat_reg   <= '0;
            irq_en_reg     <= '0;
            aw_held_reg    <= 1'b0;
            w_held_reg     <= 1'b0;
            awaddr_reg     <= 8'h00;
            wdata_reg      <= 32'h0;
            wstrb_reg      <= 4'h0;
            bvalid_reg     <= 1'b0;
            bresp_reg      <= AXI_OKAY;
            rvalid_reg     <= 1'b0;
            rresp_reg      <= AXI_OKAY;
            rdata_reg      <= 32'h0;
            mode_reg       <= MODE_ACTIVE;
            freq_reg       <= 2'h0;
            locked_reg     <= 1'b0;
            direct_irq_reg <= 1'b0;
        end else begin
            sc1_reg        <= sc1_next;
            sc2_reg        <= sc2_next;
            ch1_reg        <= ch1_next;
            irq_stat_reg   <= irq_stat_next;
            irq_en_reg     <= irq_en_next;
            aw_held_reg    <= aw_held_next;
            w_held_reg     <= w_held_next;
            awaddr_reg     <= awaddr_next;
            wdata_reg      <= wdata_next;
            wstrb_reg      <= wstrb_next;
            bvalid_reg     <= bvalid_next;
            bresp_reg      <= bresp_next;
            rvalid_reg     <= rvalid_next;
            rresp_reg      <= rresp_next;
            rdata_reg      <= rdata_next;
            mode_reg       <= mode_next;
            freq_reg       <= freq_next;
            locked_reg     <= locked_next;
            direct_irq_reg <= direct_irq_next;
        end
    end

    // ---------------- Outputs ----------------
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp  = rresp_reg;
    assign s_axi_rdata  = rdata_reg;

    assign mode_o             = mode_reg;
    assign cpu_run_o          = (mode_reg == MODE_ACTIVE) || (mode_reg == MODE_SUBACTIVE);
    assign cpu_clk_en_o       = (mode_reg == MODE_ACTIVE) ||
                                ((mode_reg == MODE_SUBACTIVE) && sub_tick);
    assign cpu_medium_speed_o = (mode_reg == MODE_ACTIVE) && med_speed;
    assign main_osc_en_o      = !sub_mode;
    assign sub_clk_en_o       = sub_tick && (mode_reg == MODE_SUBACTIVE);
    assign direct_irq_o       = direct_irq_reg;
    assign converter_standby_o = !ch1_reg[CH1_CONVERTER_BIT];
    assign irq_o              = |(irq_stat_reg & irq_en_reg);

    // Watch and watch-pass modes halt the peripheral clocks; subactive and subsleep only drop the two-wire module
    always_comb begin
        periph_clk_en_o = ch1_reg;
        if (mode_reg == MODE_WATCH || mode_reg == MODE_WATCH_PASS) begin
            periph_clk_en_o = '0;
        end else if (sub_mode) begin
            periph_clk_en_o[CH1_TWO_WIRE_BIT] = 1'b0;
        end
    end

endmodule : power_mode_transition_ctrl

/* power_mode_transition_ctrl_props.sv */
// Port-level checks for the power-mode controller
`timescale 1ns/1ps
module power_mode_transition_ctrl_props
    import power_mode_pkg::*;
(
    input  wire logic                   sys_clk_i,           // Clock
    input  wire logic                   rst_i,               // Reset
    input  wire logic                   sleep_exec_i,        // Sleep pulse
    input  wire logic                   global_mask_i,       // Mask bit
    input  wire logic                   irq_pending_i,       // Pending request
    input  wire logic [2:0]             mode_o,              // Mode
    input  wire logic                   cpu_run_o,           // Core runs
    input  wire logic                   main_osc_en_o,       // Main oscillator
    input  wire logic                   sub_clk_en_o,        // Sub clock pulse
    input  wire logic [NUM_MODULES-1:0] periph_clk_en_o,     // Module clocks
    input  wire logic                   converter_standby_o, // Converter standby
    input  wire logic                   direct_irq_o         // Direct pulse
);
    logic [11:0] pass_cnt_reg;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || mode_o != 3'h5) pass_cnt_reg <= 12'h000;
        else pass_cnt_reg <= pass_cnt_reg + 12'h001;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_sub_osc_off: assert property (
        mode_o == 3'h2 |-> !main_osc_en_o && !periph_clk_en_o[1]) else $error("clock on in subactive");
    a_lowpower_hold: assert property (
        (mode_o inside {3'h1, 3'h3, 3'h4}) && (global_mask_i || !irq_pending_i) |=> $stable(mode_o))
        else $error("low-power mode left");
    a_sub_tick_only: assert property (
        sub_clk_en_o |-> mode_o == 3'h2 ##1 !sub_clk_en_o) else $error("bad sub pulse");
    a_run_modes: assert property (
        cpu_run_o == (mode_o == 3'h0 || mode_o == 3'h2)) else $error("core run flag wrong");
    a_direct_pulse: assert property (
        direct_irq_o |-> (mode_o == 3'h0 || mode_o == 3'h2) ##1 !direct_irq_o) else $error("bad direct pulse");
    a_pass_bound: assert property (pass_cnt_reg <= 12'h5F6) else $error("watch pass too long");
    a_pass_exit: assert property (
        mode_o == 3'h5 ##1 mode_o != 3'h5 |-> mode_o == 3'h2) else $error("watch pass left wrongly");
    a_no_jump_sub: assert property (
        mode_o == 3'h0 && sleep_exec_i |=> mode_o != 3'h2) else $error("active jumped to subactive");
    a_reset_state: assert property (
        $fell(rst_i) |-> mode_o == 3'h0 && converter_standby_o) else $error("wrong state after reset");
    a_conv_gate: assert property (
        mode_o == 3'h0 |-> converter_standby_o == !periph_clk_en_o[0]) else $error("standby mismatch");
    c_sub: cover property (mode_o == 3'h2);
    c_pass: cover property (mode_o == 3'h5);
    c_direct: cover property (direct_irq_o);
endmodule : power_mode_transition_ctrl_props

bind power_mode_transition_ctrl power_mode_transition_ctrl_props u_power_mode_transition_ctrl_props (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sleep_exec_i(sleep_exec_i),
    .global_mask_i(global_mask_i), .irq_pending_i(irq_pending_i), .mode_o(mode_o),
    .cpu_run_o(cpu_run_o), .main_osc_en_o(main_osc_en_o), .sub_clk_en_o(sub_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .converter_standby_o(converter_standby_o),
    .direct_irq_o(direct_irq_o));

/* cpu_core_model.sv */
// Core model: sleep pulses and interrupt mask and pending levels
`timescale 1ns/1ps
module cpu_core_model (
    input  wire logic sys_clk_i,            // Clock
    input  wire logic sleep_req_i,          // Bench asks for a sleep
    input  wire logic mask_req_i,           // Wanted mask level
    input  wire logic pend_req_i,           // Wanted pending level
    input  wire logic cpu_run_i,            // Core executes
    output logic      sleep_exec_o = 1'b0,  // Sleep executed
    output logic      global_mask_o = 1'b0, // Mask bit
    output logic      irq_pending_o = 1'b0  // Enabled request pending
);
    // A halted core executes nothing, so its sleep requests are dropped
    always @(posedge sys_clk_i) begin
        sleep_exec_o  <= sleep_req_i && cpu_run_i && !sleep_exec_o;
        global_mask_o <= mask_req_i;
        irq_pending_o <= pend_req_i;
    end
endmodule : cpu_core_model

/* tb_top.sv */
// Self-checking bench for the power-mode controller
`timescale 1ns/1ps
module tb_top;
    import power_mode_pkg::*;
    logic        sys_clk_i = 0, rst_i = 1, slp = 0, msk = 0, pnd = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd;
    logic [1:0]  rr;
    wire logic   sx, gm, pd, awrdy, wrdy, bval, arrdy, rval, run, osc, sub, cstb, dirq, irq;
    wire logic [1:0]  rresp;
    wire logic [31:0] rdata;
    wire logic [2:0]  mode;
    wire logic [7:0]  pclk;
    int          bad_count = 0, tests_run = 0, cyc = 0, n;
    localparam int W = WATCH_TICK_CYCLES;
    power_mode_transition_ctrl u_power_mode_transition_ctrl (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy), .s_axi_bresp(),
        .s_axi_bvalid(bval), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rval),
        .s_axi_rready(rready), .sleep_exec_i(sx), .global_mask_i(gm), .irq_pending_i(pd),
        .mode_o(mode), .cpu_run_o(run), .cpu_clk_en_o(), .cpu_medium_speed_o(), .main_osc_en_o(osc),
        .sub_clk_en_o(sub), .periph_clk_en_o(pclk), .converter_standby_o(cstb),
        .direct_irq_o(dirq), .irq_o(irq));
    cpu_core_model u_cpu_core_model (.sys_clk_i(sys_clk_i), .sleep_req_i(slp), .mask_req_i(msk),
        .pend_req_i(pnd), .cpu_run_i(run), .sleep_exec_o(sx), .global_mask_o(gm),
        .irq_pending_o(pd));
    initial forever #10 sys_clk_i = ~sys_clk_i;
    // Subactive rate checks dominate, about 52k cycles
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 70000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge sys_clk_i);
            if (awrdy) awvalid <= 1'b0;
            if (wrdy) wvalid <= 1'b0;
        end while (!bval);
        bready <= 1'b0;
        #1;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        @(posedge sys_clk_i);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge sys_clk_i);
            if (arrdy) arvalid <= 1'b0;
        end while (!rval);
        {rd, rr} = {rdata, rresp};
        rready <= 1'b0;
    endtask : axr
    task automatic sleep_now();
        @(posedge sys_clk_i) slp <= 1'b1;
        @(posedge sys_clk_i) slp <= 1'b0;
        @(posedge sys_clk_i) #1;
    endtask : sleep_now
    task automatic gap();
        n = 0;
        @(posedge sys_clk_i iff sub);
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (!sub);
    endtask : gap
    task automatic do_reset();
        repeat (2) @(posedge sys_clk_i) rst_i <= 1'b1;
        @(posedge sys_clk_i) rst_i <= 1'b0;
        #1;
        chk(mode, 3'h0);
        chk(cstb, 1'b1);
    endtask : do_reset
    task automatic t_regs();
        axr(OFS_SYSTEM_CONTROL_TWO);
        chk(rd, 32'h0);
        axr(8'h40);
        chk(rr, AXI_SLVERR);
        axw(OFS_CLOCK_HALT_ONE, 32'hFC);
        chk(pclk, 8'hFC);
        axw(OFS_CLOCK_HALT_ONE, 32'hFF);
        chk(cstb, 1'b0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_direct();
        axw(OFS_SYSTEM_CONTROL_TWO, 32'h8);
        sleep_now();
        chk(dirq, 1'b1);
        chk(mode, 3'h0);
        chk(irq, 1'b0);
        axw(OFS_IRQ_ENABLE, 32'h1);
        chk(irq, 1'b1);
        axw(OFS_IRQ_CLEAR, 32'h1);
        chk(irq, 1'b0);
        $display("test direct done");
    endtask : t_direct
    task automatic t_sub();
        axw(OFS_SYSTEM_CONTROL_ONE, 32'h7);
        axw(OFS_SYSTEM_CONTROL_TWO, 32'h9);
        sleep_now();
        chk(mode, 3'h5);
        for (int i = 0; i < 2000 && mode !== 3'h2; i++) @(posedge sys_clk_i);
        chk(mode, 3'h2);
        chk({osc, pclk[1:0]}, 3'b001);
        axw(OFS_SYSTEM_CONTROL_TWO, 32'h3);
        gap();
        chk(n, 2 * W);
        sleep_now();
        chk({mode, pclk}, 11'h400);
        pnd <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        chk(mode, 3'h2);
        for (int f = 0; f < 4; f++) begin
            axw(OFS_SYSTEM_CONTROL_TWO, 32'h8 | f);
            sleep_now();
            chk({dirq, mode}, 4'hA);
            axr(OFS_MODE_STATUS);
            chk(rd[5:4], f);
            gap();
            chk(n, W << f);
        end
        axw(OFS_SYSTEM_CONTROL_ONE, 32'h0);
        sleep_now();
        chk({mode, osc}, 4'h1);
        $display("test sub done");
    endtask : t_sub
    task automatic t_mask();
        axw(OFS_SYSTEM_CONTROL_TWO, 32'h8);
        msk <= 1'b1;
        sleep_now();
        chk(mode, 3'h1);
        {pnd, msk} <= 2'b10;
        repeat (20) @(posedge sys_clk_i);
        chk(mode, 3'h1);
        axr(OFS_MODE_STATUS);
        chk(rd[8], 1'b1);
        do_reset();
        $display("test mask done");
    endtask : t_mask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        do_reset();
        t_regs();
        t_direct();
        t_sub();
        t_mask();
        tally_and_finish();
    end
endmodule : tb_top
